// ==== design/iwd_regs.svh ====
`ifndef IWD_REGS_SVH
`define IWD_REGS_SVH

// instruction word and field geometry
`define IWD_WORD_W 14
`define IWD_OP_HI 13
`define IWD_OP_LO 8
`define IWD_CLASS_HI 13
`define IWD_CLASS_LO 12
`define IWD_DEST_BIT 7
`define IWD_FILE_HI 6
`define IWD_FILE_LO 0
`define IWD_BSEL_HI 9
`define IWD_BSEL_LO 7
`define IWD_LIT8_HI 7
`define IWD_LIT11_HI 10

// register file address range
`define IWD_FILE_MIN 7'h00
`define IWD_FILE_MAX 7'h7f

// timing: oscillator periods per instruction cycle
`define IWD_OSC_PER_CYCLE 4
`define IWD_PHASE_LAST 2'h3

// don't-care masks over the six-bit operation code field
`define IWD_XMASK_LIT_LOAD 6'h03
`define IWD_XMASK_LIT_RET 6'h03
`define IWD_XMASK_LIT_SUB 6'h01
`define IWD_XMASK_LIT_ADD 6'h01
// don't-care mask over the low byte of the no_operation word
`define IWD_XMASK_IDLE 8'h60

// fixed encodings the timing logic must recognise
`define IWD_WORD_SUB_RET 14'h0008
`define IWD_WORD_INT_RET 14'h0009

`endif

// ==== design/iwd_pkg.sv ====
package iwd_pkg;

  typedef enum logic [1:0] {
    IWD_CLS_BYTE = 2'h0,
    IWD_CLS_BIT = 2'h1,
    IWD_CLS_LIT = 2'h2
  } iwd_class_e;

  typedef struct packed {
    logic valid;
    logic flush;
    logic no_operation;
    iwd_class_e op_class;
    logic [5:0] op_code;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_sel;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic pc_change;
    logic may_skip;
  } iwd_dec_s;

endpackage

// ==== design/iwd_qphase.sv ====
`timescale 1ns/100ps
`include "iwd_regs.svh"

module iwd_qphase (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [1:0] phase,
  output logic cycle_start
);

  // four oscillator periods make one instruction cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // strobe marks the first period of each instruction cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cycle_start <= 1'b0;
    end else begin
      cycle_start <= (phase == `IWD_PHASE_LAST);
    end
  end

endmodule

// ==== design/iwd_decoder.sv ====
// Behaviour
// - Each instruction is one 14-bit word split into an operation code and operand fields.
// - Every word is sorted into byte-oriented, bit-oriented or literal-and-control class.
// - For byte operations the destination bit routes the result to accumulator (0) or file (1).
// - The file register operand addresses a register from 0x00 through 0x7f.
// - For bit operations the bit selector picks one bit of the addressed 8-bit register.
// - Literal operations carry an 8-bit constant, branch targets an 11-bit constant.
// - An instruction takes one cycle, or two with a no_operation second cycle on skip or jump.
// - One instruction cycle lasts exactly four oscillator periods.
// - Don't-care bits never change the decoded operation.
`timescale 1ns/100ps
`include "iwd_regs.svh"

module iwd_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [13:0] fetch_word,
  input wire logic skip_taken,
  output iwd_pkg::iwd_dec_s dec,
  output logic [1:0] osc_phase,
  output logic instr_strobe
);

  logic cycle_start;
  logic flush_pending;
  logic take_flush;
  iwd_pkg::iwd_dec_s next_dec;

  iwd_qphase u_qphase (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase(osc_phase),
    .cycle_start(cycle_start)
  );

  assign instr_strobe = cycle_start;

  // a skip reported in the last period still counts for this instruction
  assign take_flush = flush_pending | (skip_taken & dec.valid & dec.may_skip);

  // combinational decode of the fetched word
  always_comb begin
    logic [5:0] op;
    op = fetch_word[`IWD_OP_HI:`IWD_OP_LO];
    next_dec = '0;
    next_dec.valid = 1'b1;
    next_dec.file_addr = fetch_word[`IWD_FILE_HI:`IWD_FILE_LO];
    next_dec.lit8 = fetch_word[`IWD_LIT8_HI:0];
    next_dec.lit11 = fetch_word[`IWD_LIT11_HI:0];
    // class from the top two bits
    unique case (fetch_word[`IWD_CLASS_HI:`IWD_CLASS_LO])
      2'h0: begin
        next_dec.op_class = iwd_pkg::IWD_CLS_BYTE;
        // control words share the byte group but carry no file operand
        if (op == 6'h00 && !fetch_word[`IWD_DEST_BIT] && fetch_word[3:0] != 4'h0) begin
          next_dec.op_class = iwd_pkg::IWD_CLS_LIT;
        end
      end
      2'h1: next_dec.op_class = iwd_pkg::IWD_CLS_BIT;
      2'h2: next_dec.op_class = iwd_pkg::IWD_CLS_LIT;
      2'h3: next_dec.op_class = iwd_pkg::IWD_CLS_LIT;
    endcase
    // mask don't-care bits of the literal opcodes
    if (op[5:2] == 4'hc) begin
      op = op & ~`IWD_XMASK_LIT_LOAD;
    end else if (op[5:2] == 4'hd) begin
      op = op & ~`IWD_XMASK_LIT_RET;
    end else if (op[5:1] == 5'h1e) begin
      op = op & ~`IWD_XMASK_LIT_SUB;
    end else if (op[5:1] == 5'h1f) begin
      op = op & ~`IWD_XMASK_LIT_ADD;
    end
    next_dec.op_code = op;
    // no_operation ignores its two free bits
    next_dec.no_operation = (op == 6'h00) && !fetch_word[`IWD_DEST_BIT] &&
      ((fetch_word[7:0] & ~`IWD_XMASK_IDLE) == 8'h00);
    if (next_dec.op_class == iwd_pkg::IWD_CLS_BYTE) begin
      next_dec.dest_file = fetch_word[`IWD_DEST_BIT];
    end
    if (next_dec.op_class == iwd_pkg::IWD_CLS_BIT) begin
      next_dec.bit_sel = fetch_word[`IWD_BSEL_HI:`IWD_BSEL_LO];
    end
    // literal class has no file operand
    if (next_dec.op_class == iwd_pkg::IWD_CLS_LIT) begin
      next_dec.file_addr = `IWD_FILE_MIN;
    end
    // jumps, calls and returns always change the program counter
    next_dec.pc_change = (fetch_word[13:12] == 2'h2) || (op[5:2] == 4'hd) ||
      (fetch_word == `IWD_WORD_SUB_RET) || (fetch_word == `IWD_WORD_INT_RET);
    // conditional skips: decrement/increment-skip and bit tests
    next_dec.may_skip = (op == 6'h0b) || (op == 6'h0f) || (op[5:3] == 3'h3);
  end

  // pending flush for the second, empty cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_pending <= 1'b0;
    end else if (cycle_start) begin
      flush_pending <= take_flush ? 1'b0 : next_dec.pc_change;
    end else if (skip_taken && dec.valid && dec.may_skip) begin
      flush_pending <= 1'b1;
    end
  end

  // latch the decoded word once per instruction cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec <= '0;
    end else if (cycle_start) begin
      if (take_flush) begin
        dec <= '0;
        dec.flush <= 1'b1;
        dec.no_operation <= 1'b1;
      end else begin
        dec <= next_dec;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  word_split_a: assert property (
    cycle_start && !take_flush |=> dec.valid && dec.op_code[5:2] == $past(fetch_word[13:10]))
    else $error("operation code field not taken from the word");

  class_sort_a: assert property (
    cycle_start && !take_flush && fetch_word[13:12] == 2'h1 |=>
      dec.op_class == iwd_pkg::IWD_CLS_BIT)
    else $error("bit-oriented word sorted into wrong class");

  dest_route_a: assert property (
    cycle_start && !take_flush && fetch_word[13:12] == 2'h0 && fetch_word[11:8] != 4'h0 |=>
      dec.dest_file == $past(fetch_word[7]))
    else $error("destination select not routed");

  file_range_a: assert property (
    cycle_start && !take_flush && fetch_word[13] == 1'b0 && fetch_word[11:8] != 4'h0 |=>
      dec.file_addr == $past(fetch_word[6:0]) && dec.file_addr <= `IWD_FILE_MAX)
    else $error("file register operand wrong");

  bit_pick_a: assert property (
    cycle_start && !take_flush && fetch_word[13:12] == 2'h1 |=>
      dec.bit_sel == $past(fetch_word[9:7]))
    else $error("bit selector wrong");

  literal_field_a: assert property (
    cycle_start && !take_flush |=> dec.lit8 == $past(fetch_word[7:0]) &&
      dec.lit11 == $past(fetch_word[10:0]))
    else $error("literal operand wrong");

  jump_flush_a: assert property (
    dec.valid && dec.pc_change && !$past(cycle_start) ##0 cycle_start |=>
      dec.flush && !dec.valid && !cycle_start ##1 !cycle_start [*2] ##1
      cycle_start ##1 !dec.flush)
    else $error("program counter change lacks exactly one empty cycle");

  quad_cycle_a: assert property (
    cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("instruction cycle is not four periods");

  dont_care_a: assert property (
    cycle_start && !take_flush && fetch_word[13:10] == 4'hc |=> dec.op_code == 6'h30)
    else $error("don't-care bits changed the operation");

  // flush shape and refused skips
  skip_flush_a: assert property (
    cycle_start && dec.valid && dec.may_skip && skip_taken |=>
      dec.flush && dec.no_operation && !dec.valid)
    else $error("skip at the strobe edge did not empty the next cycle");

  single_flush_a: assert property (
    cycle_start && dec.flush |=> !dec.flush)
    else $error("two empty cycles in a row");

  plain_step_a: assert property (
    cycle_start && dec.valid && !dec.may_skip && !dec.pc_change |=> !dec.flush)
    else $error("empty cycle after a plain instruction");

  flush_body_a: assert property (
    dec.flush |-> dec.no_operation && !dec.valid && !dec.pc_change && !dec.may_skip)
    else $error("empty cycle carries an operation");

  bit_skip_a: assert property (
    cycle_start && !take_flush && fetch_word[13:11] == 3'h3 |=> dec.may_skip)
    else $error("bit test not marked as a possible skip");

  phase_align_a: assert property (
    cycle_start |-> osc_phase == 2'h0)
    else $error("strobe outside the first period");

  // classification and field routing
  byte_class_a: assert property (
    cycle_start && !take_flush && fetch_word[13:12] == 2'h0 && fetch_word[11:8] != 4'h0 |=>
      dec.op_class == iwd_pkg::IWD_CLS_BYTE)
    else $error("byte-oriented word sorted into wrong class");

  lit_class_a: assert property (
    cycle_start && !take_flush && fetch_word[13] |=>
      dec.op_class == iwd_pkg::IWD_CLS_LIT && dec.file_addr == 7'h00)
    else $error("literal word sorted into wrong class");

  acc_dest_a: assert property (
    cycle_start && !take_flush && fetch_word[13:12] != 2'h0 |=> !dec.dest_file)
    else $error("destination select outside byte operations");

  // free bits must not move the decode
  idle_word_a: assert property (
    cycle_start && !take_flush && fetch_word[13:7] == 7'h00 && fetch_word[4:0] == 5'h00 |=>
      dec.no_operation && dec.op_class == iwd_pkg::IWD_CLS_BYTE)
    else $error("free bits changed the no_operation decode");

  sub_add_mask_a: assert property (
    cycle_start && !take_flush && fetch_word[13:10] == 4'hf |=>
      dec.op_code == {$past(fetch_word[13:9]), 1'b0})
    else $error("free bit changed the add or subtract literal");

  ret_lit_a: assert property (
    cycle_start && !take_flush && fetch_word[13:10] == 4'hd |=>
      dec.op_code == 6'h34 && dec.pc_change)
    else $error("free bits changed the return with literal");

endmodule

// ==== tb/iwd_fetch_model.sv ====
`timescale 1ns/100ps

module iwd_fetch_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] osc_phase,
  input wire logic [13:0] word_in,
  output logic [13:0] fetch_word
);
  // whole word fetch
  // word lands in the last phase; after the take edge the bus shows the
  // inverse, so stale data never passes for a fresh fetch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_word <= 14'h0000;
    end else if (osc_phase == 2'h3) begin
      fetch_word <= word_in;
    end else if (osc_phase == 2'h0) begin
      fetch_word <= ~fetch_word;
    end
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps

module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic skip_taken = 1'b0;
  logic [13:0] word_in = 14'h0000;
  logic [13:0] fetch_word;
  iwd_pkg::iwd_dec_s dec;
  logic [1:0] osc_phase;
  logic instr_strobe;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [13:0] corner [14] = '{14'h0000, 14'h0060, 14'h0008, 14'h0009, 14'h0063, 14'h0064,
    14'h0b85, 14'h1c7f, 14'h3000, 14'h3300, 14'h3e55, 14'h3f55, 14'h2fff, 14'h377f};

  // free running core oscillator
  always #4 clk = ~clk;

  iwd_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .fetch_word(fetch_word),
    .skip_taken(skip_taken), .dec(dec), .osc_phase(osc_phase), .instr_strobe(instr_strobe));
  iwd_fetch_model u_mem (.clk(clk), .sys_rst(sys_rst), .osc_phase(osc_phase),
    .word_in(word_in), .fetch_word(fetch_word));

  // reference decode, don't-care bits cleared as the core does
  function automatic iwd_pkg::iwd_dec_s expect_dec(input logic [13:0] w);
    iwd_pkg::iwd_dec_s d;
    d = '0;
    d.valid = 1'b1;
    d.op_code = w[13:8];
    if (w[13:10] == 4'hc || w[13:10] == 4'hd) d.op_code[1:0] = 2'h0;
    if (w[13:10] == 4'hf) d.op_code[0] = 1'b0;
    if (w[13:12] == 2'h1) d.op_class = iwd_pkg::IWD_CLS_BIT;
    else if (w[13] || (w[13:7] == 7'h00 && w[3:0] != 4'h0)) d.op_class = iwd_pkg::IWD_CLS_LIT;
    d.no_operation = (w[13:7] == 7'h00) && (w[4:0] == 5'h00);
    d.file_addr = (d.op_class == iwd_pkg::IWD_CLS_LIT) ? 7'h00 : w[6:0];
    d.dest_file = (d.op_class == iwd_pkg::IWD_CLS_BYTE) ? w[7] : 1'b0;
    d.bit_sel = (d.op_class == iwd_pkg::IWD_CLS_BIT) ? w[9:7] : 3'h0;
    d.lit8 = w[7:0];
    d.lit11 = w[10:0];
    d.pc_change = w[13:12] == 2'h2 || w[13:10] == 4'hd || w == 14'h0008 || w == 14'h0009;
    d.may_skip = w[13:8] == 6'h0b || w[13:8] == 6'h0f || w[13:11] == 3'h3;
    return d;
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // bounded wait for the edge that takes a word
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_strobe !== 1'b1 && n < 8);
    if (n == 8) begin
      n_mismatch++;
      $display("CHECK FAILED strobe expected 1 seen %b", instr_strobe);
      stop_test();
    end
  endtask

  // one instruction; skip raised in its second to fourth period, held till the next word
  task automatic run(input logic [13:0] w, input logic sk);
    iwd_pkg::iwd_dec_s e;
    int n;
    int dly;
    e = expect_dec(w);
    @(posedge clk);
    word_in <= w;
    skip_taken <= 1'b0;
    wait_strobe(n);
    @(negedge clk);
    chk("dec", e, dec);
    chk("phase", 64'h1, osc_phase);
    @(posedge clk);
    // late skip reaches the strobe edge that ends the instruction
    if (sk && e.may_skip) begin
      dly = $urandom % 3;
      repeat (dly) @(posedge clk);
    end
    skip_taken <= sk;
    if (e.pc_change || (sk && e.may_skip)) begin
      wait_strobe(n);
      @(negedge clk);
      chk("flush", 64'h3, {dec.valid, dec.flush, dec.no_operation});
    end
  endtask

  initial begin
    int n;
    void'($urandom(91010));
    repeat (12) @(posedge clk);
    chk("reset dec", 64'h0, dec);
    chk("reset phase", 64'h0, {osc_phase, instr_strobe});
    sys_rst <= 1'b0;
    wait_strobe(n);
    wait_strobe(n);
    chk("period", 64'h4, n);
    $display("reset and timing done");
    foreach (corner[i]) run(corner[i], 1'b1);
    $display("corner cases done");
    // mid-run reset: idle word and no skip, so nothing stale follows release
    @(posedge clk);
    sys_rst <= 1'b1;
    word_in <= 14'h0000;
    skip_taken <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("mid reset dec", 64'h0, dec);
    chk("mid reset phase", 64'h0, {osc_phase, instr_strobe});
    @(posedge clk);
    sys_rst <= 1'b0;
    wait_strobe(n);
    chk("first take", 64'h5, n);
    @(negedge clk);
    chk("first word", expect_dec(14'h0000), dec);
    $display("mid-run reset done");
    repeat (300) run(14'($urandom), 1'($urandom));
    $display("random words done");
    stop_test();
  end
endmodule
